// *** include/pfc_defines.vh ***
// Purpose: Constants for the port A upper pin function control block
// Assumes: Included by bare name from the design files
// Notes: Register index times four gives the Avalon byte address
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH

// ****************************************
// Register indexes (word addresses)
// ****************************************
`define IDX_UPPER_DIR 2'h0
`define IDX_LOWER_DIR 2'h1
`define IDX_UPPER_FSEL 2'h2
`define IDX_STATUS 2'h3

// ****************************************
// Reset values and writable masks
// ****************************************
`define UPPER_DIR_RESET 16'h0000
`define LOWER_DIR_RESET 16'h0000
`define UPPER_FSEL_RESET 16'h0000
`define UPPER_DIR_WMASK 16'h00FF
`define LOWER_DIR_WMASK 16'hFFFF
`define UPPER_FSEL_WMASK 16'h55F5

// ****************************************
// Function select field positions
// ****************************************
`define FS_PIN23 14
`define FS_PIN22 12
`define FS_PIN21 10
`define FS_PIN20 8
`define FS_PIN19_HI 7
`define FS_PIN19_LO 6
`define FS_PIN18_HI 5
`define FS_PIN18_LO 4
`define FS_PIN17 2
`define FS_PIN16 0

// ****************************************
// Effective pin function codes
// ****************************************
`define FUNC_GPIO 2'h0
`define FUNC_ALT_A 2'h1
`define FUNC_ALT_B 2'h2

// ****************************************
// Status register layout
// ****************************************
`define ST_SINGLE_CHIP 16
`define ST_ROM_DISABLED 17
`define ST_FULL_PACKAGE 18

`endif

// *** verilog/pin_select_cell.v ***
// Purpose: One multiplexed pin: output data and drive direction
// Assumes: Function code and direction bit come from the same clock
// Notes: Pin input passes a three stage synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.vh"

module pin_select_cell (
  input wire mclk,
  input wire resetn,
  input wire [1:0] func,
  input wire dir,
  input wire present,
  input wire gpio_out,
  input wire alt_a_out,
  input wire alt_a_oe,
  input wire alt_b_out,
  input wire alt_b_oe,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  output reg pin_sync
);

  reg [2:0] in_pipe;
  reg next_out;
  reg next_oe;

  // ****************************************
  // Output mux
  // ****************************************
  always @* begin
    next_out = gpio_out;
    next_oe = dir;
    case (func)
      `FUNC_ALT_A: begin
        next_out = alt_a_out;
        next_oe = alt_a_oe;
      end
      `FUNC_ALT_B: begin
        next_out = alt_b_out;
        next_oe = alt_b_oe;
      end
      default: begin
        next_out = gpio_out;
        next_oe = dir;
      end
    endcase
    if (!present) begin
      next_oe = 1'b0;
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      in_pipe <= 3'h0;
      pin_sync <= 1'b0;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      in_pipe <= {in_pipe[1:0], pin_in};
      if (in_pipe[1] == in_pipe[2]) begin
        pin_sync <= in_pipe[2];
      end
    end
  end

endmodule
`default_nettype wire

// *** verilog/port_a_upper_pin_function_control.v ***
// Purpose: Port A direction and upper pin function control
// Assumes: resetn is the external power-on reset only
// Notes: Other resets and low power modes never reach these registers
//
// Summary of operation
// - Upper direction bits 7:0 drive pins 23:16
// - Upper direction ignored while alternate function active
// - Power-on reset alone clears upper direction
// - Upper registers drive pins on full package only
// - Lower direction bit n drives pin n
// - Serial clock pins still follow lower direction
// - Power-on reset alone clears lower direction
// - Power-on reset alone clears upper function select
// - Operating mode overrides upper function selection
// - Reserved function select bits read zero
// - Bit 14 selects pin 23 write strobe
// - Bit 12 selects pin 22 write strobe
// - Bit 10 selects pin 21 column strobe
// - Pins 21, 20 strobes, gpio in single chip
// - Bits 7:6 select pin 19 function
// - Bits 5:4 select pin 18 function
// - Bits 2, 0 select wait and hold
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.vh"

module port_a_upper_pin_function_control (
  input wire mclk,
  input wire resetn,
  // Avalon-MM slave
  input wire [1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Chip mode straps
  input wire mode_single_chip,
  input wire mode_rom_disabled,
  input wire full_package,
  // Upper pins 23:16
  input wire [7:0] upper_gpio_out,
  input wire [7:0] upper_alt_a_out,
  input wire [7:0] upper_alt_a_oe,
  input wire [7:0] upper_alt_b_out,
  input wire [7:0] upper_alt_b_oe,
  input wire [7:0] upper_pin_in,
  output wire [7:0] upper_pin_out,
  output wire [7:0] upper_pin_oe,
  output wire [7:0] upper_pin_sync,
  output reg [15:0] upper_func,
  // Lower pins 15:0
  input wire [15:0] lower_alt_sel,
  input wire [15:0] lower_sck_sel,
  input wire [15:0] lower_alt_oe,
  output reg [15:0] lower_pin_oe
);

  // ****************************************
  // Declarations
  // ****************************************
  reg [15:0] upper_direction_reg;
  reg [15:0] lower_direction_reg;
  reg [15:0] upper_function_select_reg;
  reg [2:0] single_pipe;
  reg [2:0] rom_pipe;
  reg [2:0] pkg_pipe;
  reg single_chip;
  reg rom_disabled;
  reg package_ok;
  reg read_done;
  reg [15:0] next_upper_func;
  reg [15:0] next_lower_oe;
  reg [15:0] reg_rdata;
  wire [15:0] wr_lanes;
  wire wr_upper_dir;
  wire wr_lower_dir;
  wire wr_fsel;

  // ****************************************
  // Function select field taps
  // ****************************************
  wire pin23_function_bit;
  wire pin22_function_bit;
  wire pin21_function_bit;
  wire pin20_function_bit;
  wire pin19_function_hi;
  wire pin19_function_lo;
  wire pin18_function_hi;
  wire pin18_function_lo;
  wire pin17_function_bit;
  wire pin16_function_bit;

  // ****************************************
  // Mode strap synchronisers
  // ****************************************
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      single_pipe <= 3'h0;
      rom_pipe <= 3'h0;
      pkg_pipe <= 3'h0;
      single_chip <= 1'b0;
      rom_disabled <= 1'b0;
      package_ok <= 1'b0;
    end else begin
      single_pipe <= {single_pipe[1:0], mode_single_chip};
      rom_pipe <= {rom_pipe[1:0], mode_rom_disabled};
      pkg_pipe <= {pkg_pipe[1:0], full_package};
      if (single_pipe[1] == single_pipe[2]) begin
        single_chip <= single_pipe[2];
      end
      if (rom_pipe[1] == rom_pipe[2]) begin
        rom_disabled <= rom_pipe[2];
      end
      if (pkg_pipe[1] == pkg_pipe[2]) begin
        package_ok <= pkg_pipe[2];
      end
    end
  end

  // ****************************************
  // Avalon-MM write decode
  // ****************************************
  assign wr_lanes = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_upper_dir = avs_write && (avs_address == `IDX_UPPER_DIR);
  assign wr_lower_dir = avs_write && (avs_address == `IDX_LOWER_DIR);
  assign wr_fsel = avs_write && (avs_address == `IDX_UPPER_FSEL);

  // ****************************************
  // Avalon-MM wait state
  // ****************************************
  // Reads take one wait state, writes none
  assign avs_waitrequest = avs_read && !read_done;

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      upper_direction_reg <= `UPPER_DIR_RESET;
      lower_direction_reg <= `LOWER_DIR_RESET;
      upper_function_select_reg <= `UPPER_FSEL_RESET;
    end else begin
      if (wr_upper_dir) begin
        upper_direction_reg <= (upper_direction_reg & ~wr_lanes) |
          (avs_writedata[15:0] & wr_lanes & `UPPER_DIR_WMASK);
      end
      if (wr_lower_dir) begin
        lower_direction_reg <= (lower_direction_reg & ~wr_lanes) |
          (avs_writedata[15:0] & wr_lanes & `LOWER_DIR_WMASK);
      end
      if (wr_fsel) begin
        upper_function_select_reg <=
          (upper_function_select_reg & ~wr_lanes) |
          (avs_writedata[15:0] & wr_lanes & `UPPER_FSEL_WMASK);
      end
    end
  end

  // ****************************************
  // Avalon-MM read path
  // ****************************************
  always @* begin
    reg_rdata = 16'h0000;
    case (avs_address)
      `IDX_UPPER_DIR: begin
        reg_rdata = upper_direction_reg & `UPPER_DIR_WMASK;
      end
      `IDX_LOWER_DIR: begin
        reg_rdata = lower_direction_reg;
      end
      `IDX_UPPER_FSEL: begin
        reg_rdata = upper_function_select_reg & `UPPER_FSEL_WMASK;
      end
      `IDX_STATUS: begin
        reg_rdata = upper_func;
      end
      default: begin
        reg_rdata = 16'h0000;
      end
    endcase
  end

  // ****************************************
  // Read data capture
  // ****************************************
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      read_done <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      if (avs_read && !read_done) begin
        read_done <= 1'b1;
        avs_readdata <= {16'h0000, reg_rdata};
        if (avs_address == `IDX_STATUS) begin
          avs_readdata[`ST_SINGLE_CHIP] <= single_chip;
          avs_readdata[`ST_ROM_DISABLED] <= rom_disabled;
          avs_readdata[`ST_FULL_PACKAGE] <= package_ok;
        end
      end else begin
        read_done <= 1'b0;
      end
    end
  end

  // ****************************************
  // Function select fields
  // ****************************************
  assign pin23_function_bit = upper_function_select_reg[`FS_PIN23];
  assign pin22_function_bit = upper_function_select_reg[`FS_PIN22];
  assign pin21_function_bit = upper_function_select_reg[`FS_PIN21];
  assign pin20_function_bit = upper_function_select_reg[`FS_PIN20];
  assign pin19_function_hi = upper_function_select_reg[`FS_PIN19_HI];
  assign pin19_function_lo = upper_function_select_reg[`FS_PIN19_LO];
  assign pin18_function_hi = upper_function_select_reg[`FS_PIN18_HI];
  assign pin18_function_lo = upper_function_select_reg[`FS_PIN18_LO];
  assign pin17_function_bit = upper_function_select_reg[`FS_PIN17];
  assign pin16_function_bit = upper_function_select_reg[`FS_PIN16];

  // ****************************************
  // Effective function per upper pin
  // ****************************************
  // Two bits per pin, pin 16 in bits 1:0, pin 23 in bits 15:14
  always @* begin
    next_upper_func = {8{`FUNC_GPIO}};
    // Pin 23 upper byte write strobe
    if ((pin23_function_bit || rom_disabled) && !single_chip) begin
      next_upper_func[15:14] = `FUNC_ALT_A;
    end
    // Pin 22 second byte write strobe
    if ((pin22_function_bit || rom_disabled) && !single_chip) begin
      next_upper_func[13:12] = `FUNC_ALT_A;
    end
    // Pin 21 upper column strobe
    if (pin21_function_bit && !single_chip) begin
      next_upper_func[11:10] = `FUNC_ALT_A;
    end
    // Pin 20 lower column strobe
    if (pin20_function_bit && !single_chip) begin
      next_upper_func[9:8] = `FUNC_ALT_A;
    end
    // Pin 19 bus grant or channel 1 acknowledge
    if (!single_chip) begin
      case ({pin19_function_hi, pin19_function_lo})
        2'h1: begin
          next_upper_func[7:6] = `FUNC_ALT_A;
        end
        2'h2: begin
          next_upper_func[7:6] = `FUNC_ALT_B;
        end
        default: begin
          next_upper_func[7:6] = `FUNC_GPIO;
        end
      endcase
    end
    // Pin 18 bus request or channel 0 acknowledge
    if (!single_chip) begin
      case ({pin18_function_hi, pin18_function_lo})
        2'h1: begin
          next_upper_func[5:4] = `FUNC_ALT_A;
        end
        2'h2: begin
          next_upper_func[5:4] = `FUNC_ALT_B;
        end
        default: begin
          next_upper_func[5:4] = `FUNC_GPIO;
        end
      endcase
    end
    // Pin 17 wait request, pin 16 address hold
    if (pin17_function_bit && !single_chip) begin
      next_upper_func[3:2] = `FUNC_ALT_A;
    end
    if (pin16_function_bit && !single_chip) begin
      next_upper_func[1:0] = `FUNC_ALT_A;
    end
  end

  // ****************************************
  // Effective function register
  // ****************************************
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      upper_func <= 16'h0000;
    end else begin
      upper_func <= next_upper_func;
    end
  end

  // ****************************************
  // Upper pin cells
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_upper
      pin_select_cell u_cell (
        .mclk(mclk),
        .resetn(resetn),
        .func(upper_func[2*gi+1:2*gi]),
        .dir(upper_direction_reg[gi]),
        .present(package_ok),
        .gpio_out(upper_gpio_out[gi]),
        .alt_a_out(upper_alt_a_out[gi]),
        .alt_a_oe(upper_alt_a_oe[gi]),
        .alt_b_out(upper_alt_b_out[gi]),
        .alt_b_oe(upper_alt_b_oe[gi]),
        .pin_in(upper_pin_in[gi]),
        .pin_out(upper_pin_out[gi]),
        .pin_oe(upper_pin_oe[gi]),
        .pin_sync(upper_pin_sync[gi])
      );
    end
  endgenerate

  // ****************************************
  // Lower pin direction
  // ****************************************
  genvar li;
  generate
    for (li = 0; li < 16; li = li + 1) begin : g_lower
      always @* begin
        if (!lower_alt_sel[li] || lower_sck_sel[li]) begin
          next_lower_oe[li] = lower_direction_reg[li];
        end else begin
          next_lower_oe[li] = lower_alt_oe[li];
        end
      end
    end
  endgenerate

  // ****************************************
  // Lower drive register
  // ****************************************
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lower_pin_oe <= 16'h0000;
    end else begin
      lower_pin_oe <= next_lower_oe;
    end
  end

endmodule
`default_nettype wire

// *** testbench/pfc_asserts.sv ***
// Purpose: Port level checks for the pin function control block
// Assumes: Bound to the top module, one clock domain
// Notes: Straps pass a synchroniser, so mode checks wait 8 cycles
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.vh"

module pfc_asserts (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic mode_single_chip,
  input wire logic mode_rom_disabled,
  input wire logic full_package,
  input wire logic [7:0] upper_alt_a_oe,
  input wire logic [7:0] upper_pin_oe,
  input wire logic [15:0] upper_func,
  input wire logic [15:0] lower_alt_sel,
  input wire logic [15:0] lower_sck_sel,
  input wire logic [15:0] lower_alt_oe,
  input wire logic [15:0] lower_pin_oe
);
  // ****
  // Pins on primary alternate function
  // ****
  logic [7:0] alt_a_mask;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      alt_a_mask[i] = (upper_func[2*i +: 2] == `FUNC_ALT_A);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ****
  // Assertions
  // ****
  rd_wait_a: assert property ($rose(avs_read) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("read wait wrong");
  fsel_resv_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == `IDX_UPPER_FSEL |-> (avs_readdata[15:0] & 16'hAA0A) == 0)
    else $error("reserved select bit read high");
  dir_resv_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == `IDX_UPPER_DIR |-> avs_readdata[15:8] == 8'h00)
    else $error("upper direction high byte read high");
  alt_oe_a: assert property (full_package[*8] |->
    ((upper_pin_oe ^ $past(upper_alt_a_oe)) & $past(alt_a_mask)) == 8'h00)
    else $error("alternate pin drive not from peripheral");
  small_pkg_a: assert property (!full_package[*8] |->
    upper_pin_oe == 8'h00) else $error("small package drives a pin");
  single_gpio_a: assert property (mode_single_chip[*8] |->
    upper_func == 16'h0000) else $error("single chip pin not gpio");
  rom_force_a: assert property ((mode_rom_disabled &&
    !mode_single_chip)[*8] |-> upper_func[15:12] == 4'h5)
    else $error("write strobes not forced");
  no_resv_code_a: assert property (
    (upper_func & (upper_func >> 1) & 16'h5555) == 16'h0000)
    else $error("reserved function code active");
  lower_oe_a: assert property ($past(resetn) |->
    ((lower_pin_oe ^ $past(lower_alt_oe)) &
    $past(lower_alt_sel) & ~$past(lower_sck_sel)) == 16'h0000)
    else $error("lower alternate drive wrong");
  rd_done_c: cover property (avs_read && !avs_waitrequest);
  single_c: cover property (mode_single_chip[*8]);
  sck_c: cover property (|(lower_alt_sel & lower_sck_sel));
endmodule

bind port_a_upper_pin_function_control pfc_asserts u_pfc_asserts (
  .mclk, .resetn, .avs_address, .avs_read, .avs_readdata, .avs_waitrequest,
  .mode_single_chip, .mode_rom_disabled, .full_package, .upper_alt_a_oe,
  .upper_pin_oe, .upper_func, .lower_alt_sel, .lower_sck_sel, .lower_alt_oe,
  .lower_pin_oe);
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the pin function control block
// Assumes: Avalon reads wait one cycle, writes none
// Notes: Strap changes are given 8 cycles to settle
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.vh"

module tb_top;
  logic mclk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic [31:0] avs_writedata = 32'h0, q;
  logic [3:0] avs_byteenable = 4'hF;
  logic mode_single_chip = 1'b0, mode_rom_disabled = 1'b0;
  logic full_package = 1'b1;
  logic [7:0] upper_gpio_out = 8'h3C, upper_alt_a_out = 8'hC3;
  logic [7:0] upper_alt_a_oe = 8'h0F, upper_alt_b_out = 8'h0C;
  logic [7:0] upper_alt_b_oe = 8'hF0, upper_pin_in = 8'h5A;
  logic [15:0] lower_alt_sel = 16'h0, lower_sck_sel = 16'h0;
  logic [15:0] lower_alt_oe = 16'hAAAA;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [7:0] upper_pin_out, upper_pin_oe, upper_pin_sync;
  wire [15:0] upper_func, lower_pin_oe;
  int error_cnt = 0, total_checks = 0, cycles = 0;

  port_a_upper_pin_function_control u_port_a_upper_pin_function_control (
    .mclk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .mode_single_chip,
    .mode_rom_disabled, .full_package, .upper_gpio_out, .upper_alt_a_out,
    .upper_alt_a_oe, .upper_alt_b_out, .upper_alt_b_oe, .upper_pin_in,
    .upper_pin_out, .upper_pin_oe, .upper_pin_sync, .upper_func,
    .lower_alt_sel, .lower_sck_sel, .lower_alt_oe, .lower_pin_oe);

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic close_out;
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic rd, input logic [1:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic settle;
    repeat (8) @(posedge mclk);
  endtask
  task automatic pins(input logic [15:0] exp);
    chk({16'h0, upper_pin_out, upper_pin_oe}, {16'h0, exp});
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rd_chk(`IDX_UPPER_DIR, 32'h0);
    rd_chk(`IDX_LOWER_DIR, 32'h0);
    rd_chk(`IDX_UPPER_FSEL, 32'h0);
    for (int i = 0; i < 4; i++) bus(1'b0, i[1:0], 32'hFFFF);
    rd_chk(`IDX_UPPER_DIR, 32'h00FF);
    rd_chk(`IDX_LOWER_DIR, 32'hFFFF);
    rd_chk(`IDX_UPPER_FSEL, 32'h55F5);
    settle();
    rd_chk(`IDX_STATUS, 32'h45505);
  endtask
  task automatic t_pins;
    bus(1'b0, `IDX_UPPER_FSEL, 32'h0);
    bus(1'b0, `IDX_UPPER_DIR, 32'hA5);
    settle();
    pins(16'h3CA5);
    chk(upper_pin_sync, 32'h5A);
    upper_pin_in <= 8'hA5;
    bus(1'b0, `IDX_UPPER_FSEL, 32'h5555);
    settle();
    chk(upper_func, 32'h5555);
    chk(upper_pin_sync, 32'hA5);
    pins(16'hC30F);
    bus(1'b0, `IDX_UPPER_FSEL, 32'h55A5);
    settle();
    chk(upper_func, 32'h55A5);
    pins(16'hCF03);
    bus(1'b0, `IDX_UPPER_FSEL, 32'h55F5);
    settle();
    chk(upper_func, 32'h5505);
    pins(16'hCF07);
  endtask
  task automatic t_modes;
    mode_single_chip <= 1'b1;
    settle();
    chk(upper_func, 32'h0);
    pins(16'h3CA5);
    rd_chk(`IDX_STATUS, 32'h50000);
    mode_single_chip <= 1'b0;
    bus(1'b0, `IDX_UPPER_FSEL, 32'h0);
    mode_rom_disabled <= 1'b1;
    settle();
    chk(upper_func, 32'h5000);
    rd_chk(`IDX_STATUS, 32'h65000);
    mode_rom_disabled <= 1'b0;
    full_package <= 1'b0;
    settle();
    pins(16'h3C00);
    bus(1'b0, `IDX_UPPER_DIR, 32'h5A);
    rd_chk(`IDX_UPPER_DIR, 32'h5A);
    full_package <= 1'b1;
  endtask
  task automatic t_lower;
    avs_byteenable <= 4'h1;
    bus(1'b0, `IDX_LOWER_DIR, 32'h1200);
    avs_byteenable <= 4'hF;
    rd_chk(`IDX_LOWER_DIR, 32'hFF00);
    bus(1'b0, `IDX_LOWER_DIR, 32'h00FF);
    lower_alt_sel <= 16'hF0F0;
    lower_sck_sel <= 16'h3030;
    settle();
    chk(lower_pin_oe, 32'h80BF);
  endtask
  task automatic t_rst;
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(`IDX_UPPER_DIR, 32'h0);
    rd_chk(`IDX_LOWER_DIR, 32'h0);
    rd_chk(`IDX_UPPER_FSEL, 32'h0);
    chk(upper_func, 32'h0);
    chk(lower_pin_oe, 32'h8080);
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_pins();
    t_modes();
    t_lower();
    t_rst();
    close_out();
  end
endmodule
`default_nettype wire
